/* include/nvs_map.vh */
// register map, field layout and sizes of the nested interrupt state logic
`ifndef NVS_MAP_VH
`define NVS_MAP_VH

// ============================================================
// sizes
`define NVS_NUM_IRQ    21
`define NVS_ID_W       5
`define NVS_PRIO_W     3
`define NVS_PRIO_FLAT  63
`define NVS_GRP_W      2
`define NVS_EV_W       4
`define NVS_ADDR_W     12

// ============================================================
// register offsets (byte addresses)
`define NVS_OFF_ENABLE   12'h000
`define NVS_OFF_SETPEND  12'h004
`define NVS_OFF_CLRPEND  12'h008
`define NVS_OFF_ACTIVE   12'h00C
`define NVS_OFF_SOFTWARE_TRIGGER_REGISTER   12'h010
`define NVS_OFF_PRIGRP   12'h014
`define NVS_OFF_MODE     12'h018
`define NVS_OFF_STATUS   12'h01C
`define NVS_OFF_MASK     12'h020
`define NVS_OFF_BEST     12'h024
`define NVS_OFF_PRIO0    12'h040
`define NVS_OFF_PRIO_END 12'h094

// ============================================================
// event bits of the status and mask registers
`define NVS_EV_NMI     0
`define NVS_EV_ENTRY   1
`define NVS_EV_REPEND  2
`define NVS_EV_REPULSE 3

// ============================================================
// field positions of the best-candidate register
`define NVS_BEST_VALID 31
`define NVS_BEST_PREE  30
`define NVS_BEST_PRIO  8

// ============================================================
// reset values
`define NVS_PRIO_RST   3'h0
`define NVS_GRP_RST    2'h0
`define NVS_ZERO32     32'h00000000

`endif

/* src/nvs_line.v */
// state of one interrupt line: pending, active and edge history
`include "nvs_map.vh"

module nvs_line (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // peripheral request and line mode
  input  wire req,
  input  wire pulse_mode,
  // software controls, one-cycle strobes
  input  wire sw_set,
  input  wire sw_clr,
  // core entry and return for this line, one-cycle strobes
  input  wire enter,
  input  wire ret,
  // state
  output reg  pend,
  output reg  act,
  output wire repulse
);

  reg  req_d;
  reg  next_pend;
  reg  next_act;
  wire rise;
  wire hw_set;

  // inputs are synchronous; one flop of history finds the rising edge
  assign rise    = req & ~req_d;
  // level lines pend while high and not active; pulse lines on the edge
  assign hw_set  = pulse_mode ? rise : (req & ~act & ~enter);
  assign repulse = pulse_mode & rise & act;

  always @* begin
    next_act  = act;
    next_pend = pend;
    if (enter) begin
      next_act  = 1'b1;
      next_pend = 1'b0;
    end
    if (ret) begin
      next_act = 1'b0;
      // level lines resample the request; pulse lines keep what arrived
      if (!pulse_mode)
        next_pend = req;
      // pulse: pend already set by a pulse in the handler, else stays clear
    end
    if (sw_clr) begin
      if (pulse_mode || !req)
        next_pend = 1'b0;
    end
    // a set in the same cycle as a clear wins
    if (sw_set || hw_set)
      next_pend = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_d <= 1'b0;
      pend  <= 1'b0;
      act   <= 1'b0;
    end else begin
      req_d <= req;
      pend  <= next_pend;
      act   <= next_act;
    end
  end

endmodule // nvs_line

/* src/nvs_pick.v */
// arbiter: most urgent enabled pending line and its preemption verdict
`include "nvs_map.vh"

module nvs_pick (
  // candidates and running lines
  input  wire [`NVS_NUM_IRQ-1:0]   cand,
  input  wire [`NVS_NUM_IRQ-1:0]   act,
  // priorities, three bits per line, line 0 lowest
  input  wire [`NVS_PRIO_FLAT-1:0] prio_flat,
  input  wire [`NVS_GRP_W-1:0]     prigroup,
  // result
  output reg                       best_valid,
  output reg  [`NVS_ID_W-1:0]      best_id,
  output reg  [`NVS_PRIO_W-1:0]    best_prio,
  output reg                       preempt
);

  // group part of a priority: the low prigroup bits are subpriority
  function [`NVS_PRIO_W-1:0] grp;
    input [`NVS_PRIO_W-1:0] p;
    input [`NVS_GRP_W-1:0]  g;
    begin
      grp = p >> g;
    end
  endfunction

  integer                 i;
  reg                     run_valid;
  reg [`NVS_PRIO_W-1:0]   run_grp;
  reg [`NVS_PRIO_W-1:0]   p;

  // purely combinational so a priority rewrite counts on the next cycle
  always @* begin
    best_valid = 1'b0;
    best_id    = {`NVS_ID_W{1'b0}};
    best_prio  = {`NVS_PRIO_W{1'b0}};
    run_valid  = 1'b0;
    run_grp    = {`NVS_PRIO_W{1'b0}};
    p          = {`NVS_PRIO_W{1'b0}};
    for (i = 0; i < `NVS_NUM_IRQ; i = i + 1) begin
      p = prio_flat[i*`NVS_PRIO_W +: `NVS_PRIO_W];
      // strict compare: on a tie the lower number, met first, stays
      if (cand[i] && (!best_valid || p < best_prio)) begin
        best_valid = 1'b1;
        best_id    = i[`NVS_ID_W-1:0];
        best_prio  = p;
      end
      if (act[i] && (!run_valid || grp(p, prigroup) < run_grp)) begin
        run_valid = 1'b1;
        run_grp   = grp(p, prigroup);
      end
    end
    // only a strictly more urgent group nests over a running handler
    preempt = best_valid && (!run_valid || grp(best_prio, prigroup) < run_grp);
  end

endmodule // nvs_pick

/* src/nvs_top.v */
// nested interrupt state logic: line states, priorities, nmi and apb registers
`include "nvs_map.vh"

module nvs_top (
  // clock and reset
  input  wire                       pclk,
  input  wire                       presetn,
  // apb slave
  input  wire                       psel,
  input  wire                       penable,
  input  wire                       pwrite,
  input  wire [`NVS_ADDR_W-1:0]     paddr,
  input  wire [31:0]                pwdata,
  output reg  [31:0]                prdata,
  output wire                       pready,
  output wire                       pslverr,
  // peripheral requests
  input  wire [`NVS_NUM_IRQ-1:0]    irq_req,
  input  wire                       nmi_req,
  // core exception entry and return, one-cycle strobes
  input  wire                       exc_enter,
  input  wire [`NVS_ID_W-1:0]       exc_enter_id,
  input  wire                       exc_return,
  input  wire [`NVS_ID_W-1:0]       exc_return_id,
  input  wire                       nmi_ack,
  // to the core
  output reg                        core_irq_valid,
  output reg  [`NVS_ID_W-1:0]       core_irq_id,
  output reg                        core_nmi,
  // event interrupt
  output wire                       irq_out
);

  // ============================================================
  // decoding helpers
  function [`NVS_NUM_IRQ-1:0] onehot;
    input              en;
    input [`NVS_ID_W-1:0] id;
    begin
      onehot = {`NVS_NUM_IRQ{1'b0}};
      if (en && id < `NVS_NUM_IRQ)
        onehot[id] = 1'b1;
    end
  endfunction

  function hit;
    input [`NVS_ADDR_W-1:0] a;
    input [`NVS_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function in_prio;
    input [`NVS_ADDR_W-1:0] a;
    begin
      in_prio = (a >= `NVS_OFF_PRIO0) && (a <= `NVS_OFF_PRIO_END) && (a[1:0] == 2'h0);
    end
  endfunction

  // ============================================================
  // declarations
  reg  [`NVS_NUM_IRQ-1:0]    enable;
  reg  [`NVS_NUM_IRQ-1:0]    mode;
  reg  [`NVS_GRP_W-1:0]      prigroup;
  reg  [`NVS_EV_W-1:0]       status;
  reg  [`NVS_EV_W-1:0]       mask;
  reg  [`NVS_EV_W-1:0]       next_status;
  reg                        nmi_d;
  reg                        nmi_pend;
  reg  [31:0]                next_rdata;
  reg                        mapped;
  wire [`NVS_NUM_IRQ-1:0]    pend;
  wire [`NVS_NUM_IRQ-1:0]    act;
  wire [`NVS_NUM_IRQ-1:0]    repulse;
  wire [`NVS_PRIO_FLAT-1:0]  prio_flat;
  wire [`NVS_NUM_IRQ-1:0]    enter_vec;
  wire [`NVS_NUM_IRQ-1:0]    ret_vec;
  wire [`NVS_NUM_IRQ-1:0]    trig_vec;
  wire [`NVS_NUM_IRQ-1:0]    set_vec;
  wire [`NVS_NUM_IRQ-1:0]    clr_vec;
  wire [`NVS_NUM_IRQ-1:0]    cand;
  wire                       wr_en;
  wire                       setup_rd;
  wire [`NVS_ID_W-1:0]       prio_idx;
  wire                       best_valid;
  wire [`NVS_ID_W-1:0]       best_id;
  wire [`NVS_PRIO_W-1:0]     best_prio;
  wire                       preempt;
  wire                       nmi_rise;
  wire [`NVS_ADDR_W-1:0]     prio_off;
  wire                       prio_ok;
  wire                       sel_enable;
  wire                       sel_setpend;
  wire                       sel_clrpend;
  wire                       sel_active;
  wire                       sel_software_trigger_register;
  wire                       sel_prigrp;
  wire                       sel_mode;
  wire                       sel_status;
  wire                       sel_mask;
  wire                       sel_best;
  wire                       sel_prio;
  wire                       ev_entry;
  wire                       ev_repend;
  wire                       ev_repulse;

  // ============================================================
  // apb handshake
  // zero wait states: every access finishes in its first access cycle
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  // byte offset into the priority window; the word index keeps only the
  // low bits on purpose, the window holds fewer than 32 words
  assign prio_off = paddr - `NVS_OFF_PRIO0;
  assign prio_idx = prio_off[`NVS_ID_W+1:2];
  // the window end is decoded but has no line behind it
  assign prio_ok  = sel_prio & (prio_idx < `NVS_NUM_IRQ);

  // ============================================================
  // address decode, shared by the error flag and the read side
  assign sel_enable  = hit(paddr, `NVS_OFF_ENABLE);
  assign sel_setpend = hit(paddr, `NVS_OFF_SETPEND);
  assign sel_clrpend = hit(paddr, `NVS_OFF_CLRPEND);
  assign sel_active  = hit(paddr, `NVS_OFF_ACTIVE);
  assign sel_software_trigger_register  = hit(paddr, `NVS_OFF_SOFTWARE_TRIGGER_REGISTER);
  assign sel_prigrp  = hit(paddr, `NVS_OFF_PRIGRP);
  assign sel_mode    = hit(paddr, `NVS_OFF_MODE);
  assign sel_status  = hit(paddr, `NVS_OFF_STATUS);
  assign sel_mask    = hit(paddr, `NVS_OFF_MASK);
  assign sel_best    = hit(paddr, `NVS_OFF_BEST);
  assign sel_prio    = in_prio(paddr);

  always @* begin
    mapped = sel_enable | sel_setpend | sel_clrpend | sel_active |
             sel_software_trigger_register | sel_prigrp  | sel_mode    | sel_status |
             sel_mask   | sel_best    | sel_prio;
  end

  // the window end is mapped, so it answers without an error
  assign pslverr = psel & penable & ~mapped;

  // ============================================================
  // software strobes into the line states
  assign set_vec  = (wr_en && hit(paddr, `NVS_OFF_SETPEND)) ?
                    pwdata[`NVS_NUM_IRQ-1:0] : {`NVS_NUM_IRQ{1'b0}};
  assign trig_vec = onehot(wr_en && hit(paddr, `NVS_OFF_SOFTWARE_TRIGGER_REGISTER), pwdata[`NVS_ID_W-1:0]);
  assign clr_vec  = (wr_en && hit(paddr, `NVS_OFF_CLRPEND)) ?
                    pwdata[`NVS_NUM_IRQ-1:0] : {`NVS_NUM_IRQ{1'b0}};
  // the core stacks and unstacks on its own; here only state moves
  assign enter_vec = onehot(exc_enter, exc_enter_id);
  assign ret_vec   = onehot(exc_return, exc_return_id);

  // ============================================================
  // one state machine and one priority register per line
  genvar gi;
  generate
    for (gi = 0; gi < `NVS_NUM_IRQ; gi = gi + 1) begin : g_line
      reg [`NVS_PRIO_W-1:0] prio;

      // level sources are trusted to hold until serviced
      nvs_line u_line (
        .pclk       (pclk),
        .presetn    (presetn),
        .req        (irq_req[gi]),
        .pulse_mode (mode[gi]),
        .sw_set     (set_vec[gi] | trig_vec[gi]),
        .sw_clr     (clr_vec[gi]),
        .enter      (enter_vec[gi]),
        .ret        (ret_vec[gi]),
        .pend       (pend[gi]),
        .act        (act[gi]),
        .repulse    (repulse[gi])
      );

      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          prio <= `NVS_PRIO_RST;
        // a write beyond the last line matches no index and is dropped
        else if (wr_en && prio_ok && prio_idx == gi)
          prio <= pwdata[`NVS_PRIO_W-1:0];
      end

      assign prio_flat[gi*`NVS_PRIO_W +: `NVS_PRIO_W] = prio;
    end
  endgenerate

  // ============================================================
  // arbitration
  // a line that is already active is never offered again until return
  assign cand = pend & enable & ~act;

  nvs_pick u_pick (
    .cand       (cand),
    .act        (act),
    .prio_flat  (prio_flat),
    .prigroup   (prigroup),
    .best_valid (best_valid),
    .best_id    (best_id),
    .best_prio  (best_prio),
    .preempt    (preempt)
  );

  // ============================================================
  // non-maskable request: edge latched, not gated by any enable
  assign nmi_rise = nmi_req & ~nmi_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_d    <= 1'b0;
      nmi_pend <= 1'b0;
    end else begin
      nmi_d <= nmi_req;
      if (nmi_rise)
        nmi_pend <= 1'b1;
      else if (nmi_ack)
        nmi_pend <= 1'b0;
    end
  end

  // ============================================================
  // core request outputs, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_valid <= 1'b0;
      core_irq_id    <= {`NVS_ID_W{1'b0}};
      core_nmi       <= 1'b0;
    end else begin
      core_irq_valid <= preempt & ~exc_enter;
      core_irq_id    <= best_id;
      core_nmi       <= (nmi_pend | nmi_rise) & ~nmi_ack;
    end
  end

  // ============================================================
  // control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable   <= {`NVS_NUM_IRQ{1'b0}};
      mode     <= {`NVS_NUM_IRQ{1'b0}};
      prigroup <= `NVS_GRP_RST;
      mask     <= {`NVS_EV_W{1'b0}};
    end else if (wr_en) begin
      if (hit(paddr, `NVS_OFF_ENABLE))
        enable <= pwdata[`NVS_NUM_IRQ-1:0];
      if (hit(paddr, `NVS_OFF_MODE))
        mode <= pwdata[`NVS_NUM_IRQ-1:0];
      if (hit(paddr, `NVS_OFF_PRIGRP))
        prigroup <= pwdata[`NVS_GRP_W-1:0];
      if (hit(paddr, `NVS_OFF_MASK))
        mask <= pwdata[`NVS_EV_W-1:0];
    end
  end

  // ============================================================
  // sticky events, write one to clear; a new event beats the clear
  assign ev_entry   = |enter_vec;
  // the event counts only a level line whose source still asks; a pulse line kept pending on return is not counted
  assign ev_repend  = |(ret_vec & ~mode & irq_req);
  assign ev_repulse = |repulse;

  always @* begin
    next_status = status;
    if (wr_en && sel_status)
      next_status = next_status & ~pwdata[`NVS_EV_W-1:0];
    if (nmi_rise)
      next_status[`NVS_EV_NMI] = 1'b1;
    if (ev_entry)
      next_status[`NVS_EV_ENTRY] = 1'b1;
    if (ev_repend)
      next_status[`NVS_EV_REPEND] = 1'b1;
    if (ev_repulse)
      next_status[`NVS_EV_REPULSE] = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status <= {`NVS_EV_W{1'b0}};
    else
      status <= next_status;
  end

  assign irq_out = |(status & mask);

  // ============================================================
  // read data, captured in the setup cycle so it stands in the access cycle
  always @* begin
    next_rdata = `NVS_ZERO32;
    if (hit(paddr, `NVS_OFF_ENABLE))
      next_rdata[`NVS_NUM_IRQ-1:0] = enable;
    if (hit(paddr, `NVS_OFF_SETPEND) || hit(paddr, `NVS_OFF_CLRPEND))
      next_rdata[`NVS_NUM_IRQ-1:0] = pend;
    if (hit(paddr, `NVS_OFF_ACTIVE))
      next_rdata[`NVS_NUM_IRQ-1:0] = act;
    if (hit(paddr, `NVS_OFF_PRIGRP))
      next_rdata[`NVS_GRP_W-1:0] = prigroup;
    if (hit(paddr, `NVS_OFF_MODE))
      next_rdata[`NVS_NUM_IRQ-1:0] = mode;
    if (hit(paddr, `NVS_OFF_STATUS))
      next_rdata[`NVS_EV_W-1:0] = status;
    if (hit(paddr, `NVS_OFF_MASK))
      next_rdata[`NVS_EV_W-1:0] = mask;
    if (hit(paddr, `NVS_OFF_BEST)) begin
      next_rdata[`NVS_BEST_VALID]                      = best_valid;
      next_rdata[`NVS_BEST_PREE]                       = preempt;
      next_rdata[`NVS_BEST_PRIO +: `NVS_PRIO_W]        = best_prio;
      next_rdata[`NVS_ID_W-1:0]                        = best_id;
    end
    // the window end stores nothing, so it reads as zero
    if (prio_ok)
      next_rdata[`NVS_PRIO_W-1:0] = prio_flat[prio_idx*`NVS_PRIO_W +: `NVS_PRIO_W];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= `NVS_ZERO32;
    else if (setup_rd)
      prdata <= next_rdata;
  end

endmodule // nvs_top

/* tb/nvs_core_model.sv */
// core side model: handler entry, return and nmi acceptance
module nvs_core_model (
  // clock
  input  wire        pclk,
  // strobes to the controller
  output logic       exc_enter,
  output logic [4:0] exc_enter_id,
  output logic       exc_return,
  output logic [4:0] exc_return_id,
  output logic       nmi_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // strobes, lat gives a prompt or a slow core
  initial begin
    exc_enter = 1'b0;
    exc_return = 1'b0;
    nmi_ack = 1'b0;
    exc_enter_id = 5'h1F;
    exc_return_id = 5'h1F;
  end
  // stacking happens between these two strobes, invisible here
  task enter(input logic [4:0] id, input int lat);
    repeat (lat) @(posedge pclk);
    exc_enter <= 1'b1;
    exc_enter_id <= id;
    @(posedge pclk);
    exc_enter <= 1'b0;
    exc_enter_id <= ~id; // stale number must never be trusted
  endtask
  task leave(input logic [4:0] id, input int lat);
    repeat (lat) @(posedge pclk);
    exc_return <= 1'b1;
    exc_return_id <= id;
    @(posedge pclk);
    exc_return <= 1'b0;
    exc_return_id <= ~id;
  endtask
  task ack();
    nmi_ack <= 1'b1;
    @(posedge pclk);
    nmi_ack <= 1'b0;
  endtask
endmodule // nvs_core_model

/* tb/nvs_props.sv */
// port checker of the nested interrupt state logic
`include "nvs_map.vh"

module nvs_props (
  // clock and reset
  input wire                   pclk,
  input wire                   presetn,
  // apb handshake
  input wire                   psel,
  input wire                   penable,
  input wire                   pready,
  input wire                   pslverr,
  // nmi
  input wire                   nmi_req,
  input wire                   nmi_ack,
  input wire                   core_nmi,
  // core side
  input wire                   exc_enter,
  input wire [`NVS_ID_W-1:0]   exc_enter_id,
  input wire                   core_irq_valid,
  input wire [`NVS_ID_W-1:0]   core_irq_id
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("slave error outside an access cycle");
  a_ready_always: assert property (psel && !penable |=> pready)
    else $error("access cycle not answered");
  a_nmi_latch: assert property ($rose(nmi_req) |=> core_nmi)
    else $error("nmi edge not latched");
  a_nmi_hold: assert property (core_nmi && !nmi_ack |=> core_nmi)
    else $error("nmi dropped without acceptance");
  a_nmi_ack_clear: assert property (nmi_ack && !$rose(nmi_req) |=> !core_nmi)
    else $error("nmi still pending after acceptance");
  a_entry_drops: assert property (exc_enter && core_irq_valid && exc_enter_id == core_irq_id
    |=> !core_irq_valid)
    else $error("entered line still offered");
  a_id_range: assert property (core_irq_valid |-> core_irq_id < 5'd21)
    else $error("offered line number out of range");
  a_reset_quiet: assert property ($rose(presetn) |-> !core_irq_valid && !core_nmi)
    else $error("request offered straight after reset");
endmodule // nvs_props

bind nvs_top nvs_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .nmi_req(nmi_req),
  .nmi_ack(nmi_ack), .core_nmi(core_nmi), .exc_enter(exc_enter),
  .exc_enter_id(exc_enter_id), .core_irq_valid(core_irq_valid), .core_irq_id(core_irq_id));

/* tb/tb_nvs_top.sv */
// self-checking bench of the nested interrupt state logic
module tb_nvs_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_req = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rv;
  logic [20:0] irq_req = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_out, core_nmi, core_irq_valid, eno, reto, ack;
  wire  [4:0]  core_irq_id, eid, rid;
  int          failures = 0, tests_run = 0, mp = 0, ma = 0, seed = 32'h777b, best, i, k;
  int          pr[21];
  logic [11:0] ra[9] = '{12'h000, 12'h004, 12'h00C, 12'h014, 12'h018, 12'h01C, 12'h020,
                         12'h090, 12'h094};

  nvs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req(irq_req), .nmi_req(nmi_req), .exc_enter(eno),
    .exc_enter_id(eid), .exc_return(reto), .exc_return_id(rid), .nmi_ack(ack),
    .core_irq_valid(core_irq_valid), .core_irq_id(core_irq_id), .core_nmi(core_nmi),
    .irq_out(irq_out));
  nvs_core_model u_core (.pclk(pclk), .exc_enter(eno), .exc_enter_id(eid),
    .exc_return(reto), .exc_return_id(rid), .nmi_ack(ack));

  always #5 pclk = ~pclk;

  // ============================================================
  // helpers
  task summarize();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      summarize();
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next setup never reassigns psel in this step
    @(posedge pclk);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, rv, e);
  endtask
  // model state against pending and active registers
  task st();
    rc(12'h004, 32'(mp), "pending");
    rc(12'h00C, 32'(ma), "active");
  endtask
  // one-cycle pulse source on line 5
  task pulse();
    irq_req[5] <= 1'b1;
    @(posedge pclk);
    irq_req[5] <= 1'b0;
    @(posedge pclk);
  endtask

  // ============================================================
  // hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    summarize();
  end

  // ============================================================
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 9; i++) rc(ra[i], 32'h0, "reset value");
    xfer(1'b0, 12'h100, 32'h0);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped data", rv, 32'h0);
    xfer(1'b1, 12'h000, 32'h001FFFFF);
    // level line: source holds until serviced
    irq_req[3] <= 1'b1;
    repeat (2) @(posedge pclk);
    mp = 8;
    st();
    chk("offered", 32'(core_irq_valid), 32'h1);
    chk("offered id", 32'(core_irq_id), 32'h3);
    u_core.enter(5'd3, 1);
    mp = 0;
    ma = 8;
    st();
    u_core.leave(5'd3, 3);
    mp = 8;
    ma = 0;
    st();
    xfer(1'b1, 12'h008, 32'h8);
    st();
    irq_req[3] <= 1'b0;
    @(posedge pclk);
    xfer(1'b1, 12'h008, 32'h8);
    mp = 0;
    st();
    // pulse line 5
    xfer(1'b1, 12'h018, 32'h20);
    pulse();
    mp = 32;
    st();
    xfer(1'b1, 12'h008, 32'h20);
    mp = 0;
    st();
    pulse();
    u_core.enter(5'd5, 0);
    pulse();
    ma = 32;
    mp = 32;
    st();
    xfer(1'b1, 12'h008, 32'h20);
    mp = 0;
    st();
    u_core.leave(5'd5, 0);
    ma = 0;
    st();
    pulse();
    u_core.enter(5'd5, 2);
    pulse();
    u_core.leave(5'd5, 1);
    mp = 32;
    st();
    // software pending, then arbitration under changing priorities
    k = {$random(seed)} % 21;
    xfer(1'b1, 12'h010, 32'(k));
    mp = mp | (1 << k);
    rv = $random(seed) & 32'h001FFFFF;
    mp = mp | rv;
    xfer(1'b1, 12'h004, rv);
    st();
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 21; i++) begin
        rv = $random(seed);
        pr[i] = rv & 7;
        xfer(1'b1, 12'h040 + 12'(4 * i), rv);
      end
      repeat (2) @(posedge pclk);
      best = -1;
      for (i = 0; i < 21; i++)
        if (mp[i] && (best < 0 || pr[i] < pr[best])) best = i;
      chk("best valid", 32'(core_irq_valid), 32'h1);
      chk("best id", 32'(core_irq_id), 32'(best));
      rc(12'h090, 32'(pr[20]), "prio 20");
    end
    xfer(1'b1, 12'h008, 32'h001FFFFF);
    mp = 0;
    st();
    // grouping: line 0 runs at level 5, line 1 waits at level 2
    xfer(1'b1, 12'h040, 32'h5);
    xfer(1'b1, 12'h044, 32'h2);
    xfer(1'b1, 12'h010, 32'h0);
    repeat (3) @(posedge pclk);
    u_core.enter(5'd0, 0);
    xfer(1'b1, 12'h004, 32'h2);
    for (k = 0; k < 4; k++) begin
      xfer(1'b1, 12'h014, 32'(k));
      repeat (2) @(posedge pclk);
      chk("preempt", 32'(core_irq_valid), 32'((2 >> k) < (5 >> k)));
    end
    u_core.leave(5'd0, 0);
    xfer(1'b1, 12'h008, 32'h2);
    // nmi through status, mask and clear
    xfer(1'b1, 12'h01C, 32'hFFFFFFFF);
    rc(12'h01C, 32'h0, "status cleared");
    xfer(1'b1, 12'h020, 32'h1);
    nmi_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("nmi", 32'(core_nmi), 32'h1);
    chk("irq out", 32'(irq_out), 32'h1);
    rc(12'h01C, 32'h1, "status nmi");
    xfer(1'b1, 12'h020, 32'h0);
    @(posedge pclk);
    chk("irq masked", 32'(irq_out), 32'h0);
    xfer(1'b1, 12'h020, 32'h1);
    xfer(1'b1, 12'h01C, 32'h1);
    @(posedge pclk);
    chk("irq cleared", 32'(irq_out), 32'h0);
    u_core.ack();
    @(posedge pclk);
    chk("nmi accepted", 32'(core_nmi), 32'h0);
    nmi_req <= 1'b0;
    summarize();
  end
endmodule // tb_nvs_top
